// *** psc_power_state_control.sv ***
// Power-state control registers with decoded power state outputs.
// Assumes a plain register port: one-cycle strobes, read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_power_state_control #(
	parameter int ADDR_W = `PSC_ADDR_W,
	parameter int DATA_W = `PSC_DATA_W
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                reset,
	// Register port
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [DATA_W-1:0]   reg_rdata,
	// Power controls and decoded state
	output psc_pkg::psc_power_s      power_ctrl,
	output psc_pkg::psc_state_e      power_state,
	// Current-path switch controls
	output logic      [5:0]          positive_output_current_switches,
	output logic      [1:0]          positive_calibration_switches,
	output logic      [7:0]          negative_path_switches
);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks: the map is fixed at five address bits and sixteen data bits
	initial begin
		if (ADDR_W != `PSC_ADDR_W || DATA_W != `PSC_DATA_W) begin
			$error("psc_power_state_control: unsupported bus widths");
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Address decode
	wire hit_conv  = (reg_addr == `PSC_OFF_CONV_CTRL);
	wire hit_power = (reg_addr == `PSC_OFF_POWER_CTRL);
	wire hit_sw    = (reg_addr == `PSC_OFF_SWITCHES);

	logic [DATA_W-1:0] conv_ctrl_r;
	logic [DATA_W-1:0] power_ctrl_r;
	logic [DATA_W-1:0] switches_r;

	// Registers store whatever software writes; the fixed-pattern bits are the writer's duty
	logic [DATA_W-1:0] conv_ctrl_nxt;
	logic [DATA_W-1:0] power_ctrl_nxt;
	logic [DATA_W-1:0] switches_nxt;
	assign conv_ctrl_nxt  = (reg_wr && hit_conv)  ? reg_wdata : conv_ctrl_r;
	assign power_ctrl_nxt = (reg_wr && hit_power) ? reg_wdata : power_ctrl_r;
	assign switches_nxt   = (reg_wr && hit_sw)    ? reg_wdata : switches_r;

	// Register storage
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			conv_ctrl_r  <= `PSC_CONV_CTRL_RST;
			power_ctrl_r <= `PSC_POWER_CTRL_RST;
			switches_r   <= `PSC_SWITCHES_RST;
		end else begin
			conv_ctrl_r  <= conv_ctrl_nxt;
			power_ctrl_r <= power_ctrl_nxt;
			switches_r   <= switches_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Decode from next values so outputs follow a write on the very next edge
	psc_pkg::psc_state_e state_nxt;
	psc_pkg::psc_power_s power_nxt;

	psc_decode u_decode (
		.shared_converter_power_off (power_ctrl_nxt[`PSC_BIT_SHARED_OFF]),
		.global_power_on            (power_ctrl_nxt[`PSC_BIT_GLOBAL_ON]),
		.impedance_frontend_enable  (power_ctrl_nxt[`PSC_BIT_IMP_EN]),
		.weigh_frontend_enable      (power_ctrl_nxt[`PSC_BIT_WEIGH_EN]),
		.converter_power_down       (conv_ctrl_nxt[`PSC_BIT_CONV_PD]),
		.state                      (state_nxt),
		.power                      (power_nxt)
	);

	// Read mux; unmapped addresses read zero
	wire [DATA_W-1:0] rdata_nxt =
		hit_conv  ? conv_ctrl_r :
		hit_power ? power_ctrl_r :
		hit_sw    ? switches_r : '0;

	// Output flops
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata                        <= 16'h0000;
			power_ctrl                       <= '0;
			power_state                      <= psc_pkg::PSC_FULL_OFF;
			positive_output_current_switches <= 6'h00;
			positive_calibration_switches    <= 2'h0;
			negative_path_switches           <= 8'h00;
		end else begin
			reg_rdata   <= reg_rd ? rdata_nxt : 16'h0000;
			power_ctrl  <= power_nxt;
			power_state <= state_nxt;
			positive_output_current_switches <= switches_nxt[`PSC_SW_POS_CUR_HI:`PSC_SW_POS_CUR_LO];
			positive_calibration_switches    <= switches_nxt[`PSC_SW_POS_CAL_HI:`PSC_SW_POS_CAL_LO];
			negative_path_switches           <= switches_nxt[7:0];
		end
	end

endmodule

// *** psc_map.svh ***
// Register offsets, field positions and reset values of the power-state control block.
// Assumes word-addressed register port with 16-bit data.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_ADDR_W          5
`define PSC_DATA_W          16
`define PSC_OFF_CONV_CTRL   5'h01
`define PSC_OFF_POWER_CTRL  5'h09
`define PSC_OFF_SWITCHES    5'h0A
`define PSC_CONV_CTRL_RST   16'h0080
`define PSC_POWER_CTRL_RST  16'h0000
`define PSC_SWITCHES_RST    16'h0000
`define PSC_BIT_WEIGH_EN    0
`define PSC_BIT_IMP_EN      1
`define PSC_BIT_GLOBAL_ON   2
`define PSC_BIT_SHARED_OFF  3
`define PSC_BIT_CONV_PD     7
`define PSC_SW_POS_CUR_HI   15
`define PSC_SW_POS_CUR_LO   10
`define PSC_SW_POS_CAL_HI   9
`define PSC_SW_POS_CAL_LO   8
`define PSC_STATE_W         3

`endif

// *** psc_pkg.sv ***
// Types shared by the power-state control block.
// Assumes psc_map.svh is available for field positions.
package psc_pkg;

	// Decoded power state of the front-end
	typedef enum logic [2:0] {
		PSC_FULL_OFF,
		PSC_SLEEP,
		PSC_IMPEDANCE,
		PSC_WEIGH,
		PSC_AUX,
		PSC_UNDEFINED
	} psc_state_e;

	// Power controls driven to the analog domains
	typedef struct packed {
		logic shared_conv_on;
		logic frontend_on;
		logic impedance_on;
		logic weigh_on;
		logic converter_on;
	} psc_power_s;

endpackage

// *** psc_decode.sv ***
// Combinational power-state decoder.
// Assumes control bits come from registers in the same clock domain.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_decode (
	// Control bits
	input  wire logic                shared_converter_power_off,
	input  wire logic                global_power_on,
	input  wire logic                impedance_frontend_enable,
	input  wire logic                weigh_frontend_enable,
	input  wire logic                converter_power_down,
	// Decoded result
	output psc_pkg::psc_state_e      state,
	output psc_pkg::psc_power_s      power
);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Analog domain enables; each bit acts by itself so unlisted combinations still behave sanely
	assign power.shared_conv_on = global_power_on & ~shared_converter_power_off;
	assign power.frontend_on    = global_power_on;
	assign power.impedance_on   = global_power_on & impedance_frontend_enable;
	assign power.weigh_on       = global_power_on & weigh_frontend_enable;
	assign power.converter_on   = ~converter_power_down;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Mode table; combinations outside it report undefined
	wire fe_none = ~impedance_frontend_enable & ~weigh_frontend_enable;
	wire imp_only = impedance_frontend_enable & ~weigh_frontend_enable;
	wire ws_only  = weigh_frontend_enable & ~impedance_frontend_enable;
	wire run_ok   = global_power_on & ~shared_converter_power_off & ~converter_power_down;

	assign state =
		(!global_power_on && fe_none && converter_power_down) ? psc_pkg::PSC_FULL_OFF :
		(global_power_on && shared_converter_power_off && fe_none && converter_power_down)
			? psc_pkg::PSC_SLEEP :
		(run_ok && imp_only) ? psc_pkg::PSC_IMPEDANCE :
		(run_ok && ws_only)  ? psc_pkg::PSC_WEIGH :
		(run_ok && fe_none)  ? psc_pkg::PSC_AUX :
		psc_pkg::PSC_UNDEFINED;

endmodule

// *** psc_power_state_control_assertions.sv ***
// Port checker for the power-state control block.
// Assumes it is bound onto the top module and sees its ports only.
`timescale 1ns/1ps
module psc_power_state_control_assertions #(
	parameter int ADDR_W = 5,
	parameter int DATA_W = 16
) (
	// Clock, reset and write side of the register port
	input wire logic              sys_clk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	// Decoded outputs and the output current switches
	input psc_pkg::psc_power_s    power_ctrl,
	input psc_pkg::psc_state_e    power_state,
	input wire logic [5:0]        positive_output_current_switches
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	// Write to the power word, the cause of every decode below except rst_state_a, conv_pd_a and out_sw_a
	sequence wr_pwr;
		reg_wr && reg_addr == 5'h09;
	endsequence
	// Reset overrides the enable, so it is checked without it
	rst_state_a: assert property (disable iff (1'b0) reset |=> power_state == psc_pkg::PSC_FULL_OFF)
		else $error("state not off after reset");
	glob_off_a: assert property (wr_pwr ##0 !reg_wdata[2] |=> power_ctrl[4:1] == 4'h0)
		else $error("enable left on with global power off");
	weigh_en_a: assert property (wr_pwr ##0 reg_wdata[2] |=> power_ctrl.weigh_on == $past(reg_wdata[0]))
		else $error("weigh enable wrong");
	shared_conv_a: assert property (wr_pwr |=> power_ctrl.shared_conv_on == ($past(reg_wdata[2]) && !$past(reg_wdata[3])))
		else $error("shared converter power wrong");
	conv_pd_a: assert property (reg_wr && reg_addr == 5'h01 |=> power_ctrl.converter_on == !$past(reg_wdata[7]))
		else $error("converter power wrong");
	out_sw_a: assert property (reg_wr && reg_addr == 5'h0A |=> positive_output_current_switches == $past(reg_wdata[15:10]))
		else $error("output current switches wrong");
	imp_mode_a: assert property (wr_pwr ##0 (reg_wdata[3:0] == 4'h6 && power_ctrl.converter_on)
		|=> power_state == psc_pkg::PSC_IMPEDANCE)
		else $error("impedance mode not decoded");
	full_off_a: assert property (wr_pwr ##0 (reg_wdata[2:0] == 3'h0 && !power_ctrl.converter_on)
		|=> power_state == psc_pkg::PSC_FULL_OFF)
		else $error("full power-down not decoded");
endmodule

// *** psc_power_state_control_tb.sv ***
// Self-checking bench for the power-state control block.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
module psc_power_state_control_tb;
	typedef struct packed {logic [4:0] a; logic [15:0] d; psc_pkg::psc_state_e s;} psc_row_s;
	logic                sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [4:0]          reg_addr = 5'h00;
	logic [15:0]         reg_wdata = 16'h0000, reg_rdata;
	logic [5:0]          pos_sw;
	logic [1:0]          cal_sw;
	logic [7:0]          neg_sw;
	psc_pkg::psc_power_s power_ctrl;
	psc_pkg::psc_state_e power_state;
	int                  miscompares = 0, n_tests = 0, cycles = 0;
	// Write, expected decode; each row is read back afterwards
	// Power words keep bits 15 and 12:4 at zero, 14:13 at one
	// Only one front-end enable at a time, except the last row on purpose
	psc_row_s rows [8] = '{'{5'h09, 16'h6000, psc_pkg::PSC_FULL_OFF}, '{5'h09, 16'h6008, psc_pkg::PSC_FULL_OFF},
		'{5'h09, 16'h600C, psc_pkg::PSC_SLEEP}, '{5'h01, 16'h0000, psc_pkg::PSC_UNDEFINED},
		'{5'h09, 16'h6006, psc_pkg::PSC_IMPEDANCE}, '{5'h09, 16'h6005, psc_pkg::PSC_WEIGH},
		'{5'h09, 16'h6004, psc_pkg::PSC_AUX}, '{5'h09, 16'h6007, psc_pkg::PSC_UNDEFINED}};
	psc_power_state_control u_psc_power_state_control (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_ctrl(power_ctrl),
		.power_state(power_state), .positive_output_current_switches(pos_sw), .positive_calibration_switches(cal_sw),
		.negative_path_switches(neg_sw));
	////////////////////////////////////////////////////////////////
	// Clock and a hang guard well above the expected 65 cycles
	always begin
		#20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 400) begin
			miscompares++;
			stop_test();
		end
	end
	// Compare tasks, one per kind of result
	task automatic chk(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chks(input psc_pkg::psc_state_e got, exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: state %0d want %0d", $time, got, exp);
		end
	endtask
	// Bus cycles; read data stand only in the cycle after the strobe
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(reg_rdata, exp);
		@(posedge sys_clk);
	endtask
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Reset values, mode table, switches, then a reset in mid-run
	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rdc(5'h09, 16'h0000);
		rdc(5'h0A, 16'h0000);
		rdc(5'h01, 16'h0080);
		rdc(5'h1F, 16'h0000);
		$display("reset values done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			@(negedge sys_clk);
			chks(power_state, rows[i].s);
			@(posedge sys_clk);
			rdc(rows[i].a, rows[i].d);
		end
		$display("mode table done");
		wr(5'h09, 16'h6006);
		@(negedge sys_clk);
		chk({11'h000, power_ctrl}, 16'h001D);
		@(posedge sys_clk);
		wr(5'h0A, 16'hFCA5);
		@(negedge sys_clk);
		chk({10'h000, pos_sw}, 16'h003F);
		chk({14'h0000, cal_sw}, 16'h0000);
		chk({8'h00, neg_sw}, 16'h00A5);
		@(posedge sys_clk);
		reset <= 1'b1;
		@(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		chks(power_state, psc_pkg::PSC_FULL_OFF);
		@(posedge sys_clk);
		rdc(5'h0A, 16'h0000);
		$display("switches and second reset done");
		stop_test();
	end
endmodule

// Checker beside the top module, parameters handed on
bind psc_power_state_control psc_power_state_control_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
	.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.power_ctrl(power_ctrl), .power_state(power_state),
	.positive_output_current_switches(positive_output_current_switches));
